// File: sim/sdc_ctl_model.sv
// Controller model: drives command, mask and write data pins.
// Assumes one clock shared with the memory block.
`timescale 1ns/1ps
module sdc_ctl_model
    import sdc_pkg::*;
(
    input  wire logic        clk_i,
    output sdc_strobe_t      strobe_o,
    output logic [1:0]       ba_o,
    output logic [ROW_W-1:0] addr_o,
    output logic [LANES-1:0] dqm_o,
    output logic [DQ_W-1:0]  dq_o
);
    logic [DQ_W-1:0] last_r = 16'h0000;
    // Idle bus carries a no-op, never an undefined command
    initial begin
        strobe_o = 4'h7;
        ba_o = 2'h0;
        addr_o = 12'h000;
        dqm_o = 2'h0;
        dq_o = 16'hFFFF;
    end
    // One command per cycle, driven mid-cycle so it is stable at the edge
    task automatic cyc(input logic [3:0] s, input logic [1:0] b, input logic [11:0] a,
                       input logic [1:0] m, input logic [15:0] d, input logic drv);
        @(negedge clk_i);
        strobe_o = s;
        ba_o = b;
        addr_o = a;
        dqm_o = m;
        dq_o = drv ? d : ~last_r; // Released bus never shows stale data
        if (drv) last_r = d;
    endtask
endmodule // sdc_ctl_model

// File: sim/testbench.sv
// Testbench: command sequences through the controller model, reads checked.
// Assumes the x16 geometry; burst 4 at latency 2, later at latency 3.
`timescale 1ns/1ps
module testbench;
    import sdc_pkg::*;
    localparam logic [3:0] NOP = 4'h7, ACT = 4'h3, RD = 4'h5, WR = 4'h4;
    localparam logic [3:0] TRM = 4'h6, PRE = 4'h2, REF = 4'h1, MLD = 4'h0;
    logic clk_i = 1'b0, reset_i = 1'b1, cke = 1'b1, ill_q, sr_q;
    sdc_strobe_t  stb;
    logic [1:0]   ba, dqm, oe;
    logic [11:0]  addr, rrow;
    logic [15:0]  wd, rq;
    logic [15:0]  mem_w [4] = '{16'h22AA, 16'h11AB, 16'h22AC, 16'h22AD};
    int err_total = 0, comparisons = 0;
    sdc_ctl_model u_ctl (.clk_i(clk_i), .strobe_o(stb), .ba_o(ba), .addr_o(addr),
                         .dqm_o(dqm), .dq_o(wd));
    sdc_core u_dut (.clk_i(clk_i), .reset_i(reset_i), .cke_i(cke), .strobe_i(stb),
                    .ba_i(ba), .addr_i(addr), .dqm_i(dqm), .dq_i(wd), .dq_o(rq),
                    .dq_oe_o(oe), .illegal_cmd_o(ill_q), .self_refresh_o(sr_q),
                    .refresh_row_o(rrow));
    ////////////////////////////////////////
    // Clock and watchdog; the power-up pause dominates run time
    initial forever #2.5 clk_i = ~clk_i;
    initial begin
        #250000;
        err_total++;
        close_out;
    end
    task automatic chk_data(input logic [15:0] g, input logic [15:0] e);
        comparisons++;
        if (g !== e) begin
            err_total++;
            $display("CHECK FAILED %0t data %h exp %h", $time, g, e);
        end
    endtask
    task automatic chk_flag(input logic g, input logic e);
        comparisons++;
        if (g !== e) begin
            err_total++;
            $display("CHECK FAILED %0t flag %b exp %b", $time, g, e);
        end
    endtask
    task automatic nop(input int n);
        repeat (n) u_ctl.cyc(NOP, 2'h0, 12'h000, 2'h0, 16'h0000, 1'b0);
    endtask
    // Command, then the refusal pulse one edge later
    task automatic ill(input logic [3:0] s, input logic [1:0] b, input logic [11:0] a,
                       input logic e);
        u_ctl.cyc(s, b, a, 2'h0, 16'h0000, 1'b0);
        nop(1);
        chk_flag(ill_q, e);
    endtask
    task automatic wr(input logic [11:0] a, input logic [15:0] base, input logic [1:0] m1);
        for (int k = 0; k < 4; k++)
            u_ctl.cyc(k == 0 ? WR : NOP, 2'h0, a, k == 1 ? m1 : 2'h0, base + 16'(k), 1'b1);
    endtask
    // Burst read from bank 0 at latency cl; at latency two a command-edge mask floats beat 0
    task automatic rdc(input logic [11:0] a, input logic [1:0] m0, input int cl);
        logic [1:0]  idx;
        logic [1:0]  m;
        logic [15:0] lm;
        u_ctl.cyc(RD, 2'h0, a, m0, 16'h0000, 1'b0);
        nop(cl - 1);
        for (int k = 0; k < 4; k++) begin
            nop(1);
            idx = a[1:0] + 2'(k);
            m = (k == 0) ? m0 : 2'h0;
            lm = {{8{~m[1]}}, {8{~m[0]}}};
            chk_data({14'h0, oe}, {14'h0, ~m});
            chk_data(rq & lm, mem_w[idx] & lm);
        end
    endtask
    task automatic close_out;
        $display("comparisons %0d err_total %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    ////////////////////////////////////////
    // Power-up pause, two refreshes, mode load and its delay
    task automatic t_init;
        repeat (20000) @(negedge clk_i);
        ill(REF, 2'h0, 12'h000, 1'b0);
        nop(4);
        ill(REF, 2'h0, 12'h000, 1'b0);
        chk_data({4'h0, rrow}, 16'h0002);
        u_ctl.cyc(MLD, 2'h0, 12'h022, 2'h0, 16'h0000, 1'b0);
        ill(ACT, 2'h1, 12'h001, 1'b1);
        nop(1);
    endtask
    // Activate, refused commands, masked writes, wrapped reads
    task automatic t_access;
        ill(ACT, 2'h0, 12'hFFF, 1'b0);
        nop(2);
        ill(ACT, 2'h0, 12'h001, 1'b1);
        ill(RD, 2'h1, 12'h000, 1'b1);
        wr(12'h004, 16'h1100, 2'h0);
        wr(12'h004, 16'h22AA, 2'b10);
        nop(1);
        rdc(12'h004, 2'b01, 2);
        rdc(12'h406, 2'h0, 2);
        nop(8);
        ill(RD, 2'h0, 12'h004, 1'b1);
        ill(ACT, 2'h0, 12'h007, 1'b0);
        nop(3);
    endtask
    // Terminate leaves only beat 0 on the bus; precharge all; deselect
    task automatic t_term_pre;
        u_ctl.cyc(RD, 2'h0, 12'h004, 2'h0, 16'h0000, 1'b0);
        u_ctl.cyc(TRM, 2'h0, 12'h000, 2'h0, 16'h0000, 1'b0);
        nop(1);
        chk_data({14'h0, oe}, 16'h0003);
        nop(1);
        chk_data({14'h0, oe}, 16'h0000);
        nop(2);
        ill(PRE, 2'h3, 12'h400, 1'b0);
        nop(4);
        ill(RD, 2'h0, 12'h000, 1'b1);
        u_ctl.cyc(4'hB, 2'h0, 12'h005, 2'h0, 16'h0000, 1'b0);
        nop(4);
        ill(RD, 2'h0, 12'h000, 1'b1);
    endtask
    // Self refresh with clock enable low, exit, then activate
    task automatic t_selfref;
        cke = 1'b0;
        u_ctl.cyc(REF, 2'h0, 12'h000, 2'h0, 16'h0000, 1'b0);
        nop(1);
        chk_flag(sr_q, 1'b1);
        cke = 1'b1;
        nop(4);
        ill(ACT, 2'h0, 12'h001, 1'b0);
    endtask
    // Latency three; the read comes at the first edge after the activate delay
    task automatic t_cl3;
        nop(2);
        ill(PRE, 2'h0, 12'h000, 1'b0);
        nop(4);
        ill(MLD, 2'h0, 12'h032, 1'b0);
        nop(1);
        ill(ACT, 2'h0, 12'hFFF, 1'b0);
        nop(2);
        rdc(12'h004, 2'h0, 3);
    endtask
    // Main sequence: reset for three cycles, then the scenarios
    initial begin
        repeat (3) @(negedge clk_i);
        reset_i = 1'b0;
        t_init;
        t_access;
        t_term_pre;
        t_selfref;
        t_cl3;
        close_out;
    end
endmodule // testbench

// File: verilog/sdc_core.sv
// SDRAM command interface: strobe decode, per-bank state, burst engine,
// array storage, read FIFO and byte-mask handling on the data bus.
// Assumes the controller drives all inputs synchronous to clk_i.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Read data FIFO; depth covers the longest read latency
module sdc_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 4
) (
    input  wire logic             clk_i,
    input  wire logic             reset_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic      [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0]    wr_ptr_r;
    logic [AW-1:0]    rd_ptr_r;
    logic [AW:0]      count_r;
    logic             push;
    logic             pop;

    assign in_ready_o  = (count_r != (AW+1)'(DEPTH));
    assign out_valid_o = (count_r != '0);
    assign out_data_o  = mem_r[rd_ptr_r];
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;

    // Storage and pointers
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r  <= '0;
        end else begin
            if (push) begin
                mem_r[wr_ptr_r] <= in_data_i;
                wr_ptr_r        <= (wr_ptr_r == AW'(DEPTH-1)) ? '0 : wr_ptr_r + 1'b1;
            end
            if (pop) begin
                rd_ptr_r <= (rd_ptr_r == AW'(DEPTH-1)) ? '0 : rd_ptr_r + 1'b1;
            end
            count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule // sdc_fifo

////////////////////////////////////////////////////////////////////////////////
// Function
// - All command, address, mask and write data sampled on rising clock only.
// - Four banks of 4096 rows; columns 1024, 512 or 256 by width.
// - Activate opens the row on the address lines in the selected bank.
// - Read and write take the starting column from the low address bits.
// - Accesses are bursts of programmed length and order after an activate; order is always sequential here.
// - Decode inhibit, no-op, activate, read and write from the strobes.
// - Decode terminate, precharge, refresh and mode load from the strobes.
// - Deselected device ignores commands; running operations continue.
// - No-op disturbs nothing; controller uses it in idle and wait cycles.
// - Mode load only with all banks idle; op-code from address and bank.
// - Row stays open until precharge; precharge before opening another row.
// - Address bit ten selects auto precharge for that single access only.
// - Auto precharge closes the row at burst end; otherwise row stays open.
// - Precharge closes one selected bank, or all banks with bit ten high.
// - Refresh encoding is auto refresh with clock enable high, else self refresh.
// - Refresh rows come from the internal counter; other inputs are ignored.
// - Read byte mask high floats those data lines two clocks later.
// - Write byte mask high in the data cycle leaves that byte unwritten.
// - Burst terminate stops the current burst, with or without data present.
// - Write auto precharge starts after one clock plus the recovery delay.
module sdc_core
    import sdc_pkg::*;
(
    input  wire logic                clk_i,
    input  wire logic                reset_i,
    input  wire logic                cke_i,
    input  wire sdc_strobe_t         strobe_i,
    input  wire logic [1:0]          ba_i,
    input  wire logic [ROW_W-1:0]    addr_i,
    input  wire logic [LANES-1:0]    dqm_i,
    input  wire logic [DQ_W-1:0]     dq_i,
    output logic      [DQ_W-1:0]     dq_o,
    output logic      [LANES-1:0]    dq_oe_o,
    output logic                     illegal_cmd_o,
    output logic                     self_refresh_o,
    output logic      [ROW_W-1:0]    refresh_row_o
);
    logic [DQ_W-1:0]  mem_r [MEM_WORDS];
    sdc_bank_st_t     bank_st_r [BANKS];
    logic [3:0]       bank_tmr_r [BANKS];
    logic [ROW_W-1:0] open_row_r [BANKS];
    logic [MODE_W-1:0] mode_r;
    logic [1:0]       mrd_cnt_r;
    logic [1:0]       xsr_cnt_r;
    logic             bst_act_r;
    logic             bst_wr_r;
    logic             bst_ap_r;
    logic [1:0]       bst_bank_r;
    logic [COL_W-1:0] bst_col_r;
    logic [8:0]       bst_cnt_r;
    logic [2:0]       due_r;
    logic [LANES-1:0] dqm_p1_r;
    logic             out_vld_r;
    sdc_cmd_t         cmd;
    logic             accept;
    logic             all_idle;
    logic             legal;
    logic             exec_act;
    logic             exec_rdwr;
    logic             exec_pre;
    logic             exec_term;
    logic             exec_aref;
    logic             exec_sref;
    logic             exec_mode;
    logic             is_wr;
    logic [8:0]       bl_len;
    logic [COL_W-1:0] bl_mask;
    logic             cl3;
    logic             bst_stop;
    logic             rd_beat;
    logic             wr_beat;
    logic             beat_done;
    logic             burst_end;
    logic [1:0]       beat_bank;
    logic [COL_W-1:0] beat_start;
    logic [COL_W-1:0] beat_off;
    logic [COL_W-1:0] beat_col;
    logic [21:0]      beat_addr;
    logic             fifo_in_ready;
    logic             fifo_out_valid;
    logic [DQ_W-1:0]  fifo_out_data;
    logic             pop_due;

    ////////////////////////////////////////////////////////////////////////////
    // Command decode and legality against bank state
    assign cmd    = sdc_decode(strobe_i);
    // Deselect, power-down and self refresh exit all swallow commands
    assign accept = cke_i && !self_refresh_o && (xsr_cnt_r == '0)
                    && cmd != CMD_INHIBIT && cmd != CMD_NOP;

    always_comb begin
        all_idle = 1'b1;
        for (int b = 0; b < BANKS; b++) begin
            if (bank_st_r[b] != BK_IDLE) all_idle = 1'b0;
        end
    end

    always_comb begin
        legal = (mrd_cnt_r == '0);
        unique case (cmd)
            CMD_ACT:                 legal = legal && bank_st_r[ba_i] == BK_IDLE;
            CMD_READ, CMD_WRITE:     legal = legal && (bank_st_r[ba_i] == BK_ACTIVE
                                        || bank_st_r[ba_i] == BK_READING
                                        || bank_st_r[ba_i] == BK_WRITING);
            CMD_REFRESH, CMD_MODE_LOAD: legal = legal && all_idle;
            default:                 legal = legal;
        endcase
    end

    assign exec_act  = accept && legal && cmd == CMD_ACT;
    assign exec_rdwr = accept && legal && (cmd == CMD_READ || cmd == CMD_WRITE);
    assign exec_pre  = accept && legal && cmd == CMD_PRE;
    assign exec_term = accept && legal && cmd == CMD_TERM;
    assign exec_aref = accept && legal && cmd == CMD_REFRESH;
    assign exec_mode = accept && legal && cmd == CMD_MODE_LOAD;
    assign exec_sref = !cke_i && !strobe_i.cs_n && !self_refresh_o && all_idle
                       && sdc_decode(strobe_i) == CMD_REFRESH;
    assign is_wr     = (cmd == CMD_WRITE);

    ////////////////////////////////////////////////////////////////////////////
    // Mode register fields: burst length and read latency
    always_comb begin
        unique case (mode_r[MODE_BL_LSB +: 3])
            3'h0:        bl_len = 9'h001;
            3'h1:        bl_len = 9'h002;
            3'h2:        bl_len = 9'h004;
            3'h3:        bl_len = 9'h008;
            BL_FULLPAGE: bl_len = 9'(COLS_X16);
            default:     bl_len = 9'h001;
        endcase
    end
    assign bl_mask = COL_W'(bl_len - 9'h001);
    assign cl3     = (mode_r[MODE_CL_LSB +: 3] == CL_THREE);

    // Mode load takes the op-code from bank and address lines
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            mode_r    <= MODE_RST;
            mrd_cnt_r <= '0;
        end else if (exec_mode) begin
            mode_r    <= {ba_i, addr_i};
            mrd_cnt_r <= 2'(T_MRD_CLK - 1);
        end else if (mrd_cnt_r != '0) begin
            mrd_cnt_r <= mrd_cnt_r - 2'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Burst engine; beat zero happens on the command edge itself
    assign bst_stop   = bst_act_r && (exec_term
                        || (exec_pre && (addr_i[AP_BIT] || ba_i == bst_bank_r)));
    assign beat_bank  = exec_rdwr ? ba_i : bst_bank_r;
    assign beat_start = exec_rdwr ? addr_i[COL_W-1:0] : bst_col_r;
    assign beat_off   = exec_rdwr ? '0 : bst_cnt_r[COL_W-1:0];
    // Sequential order wrapping inside the burst-aligned block
    assign beat_col   = (beat_start & ~bl_mask) | ((beat_start + beat_off) & bl_mask);
    assign beat_addr  = {beat_bank, open_row_r[beat_bank], beat_col};
    assign rd_beat    = exec_rdwr ? !is_wr
                        : (bst_act_r && !bst_wr_r && !bst_stop && fifo_in_ready);
    assign wr_beat    = exec_rdwr ? is_wr : (bst_act_r && bst_wr_r && !bst_stop);
    assign beat_done  = (exec_rdwr ? 9'h001 : bst_cnt_r + 9'h001) == bl_len;
    assign burst_end  = (rd_beat || wr_beat) && beat_done;

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            bst_act_r  <= 1'b0;
            bst_wr_r   <= 1'b0;
            bst_ap_r   <= 1'b0;
            bst_bank_r <= '0;
            bst_col_r  <= '0;
            bst_cnt_r  <= '0;
        end else if (exec_rdwr) begin
            bst_act_r  <= !beat_done;
            bst_wr_r   <= is_wr;
            bst_ap_r   <= addr_i[AP_BIT];
            bst_bank_r <= ba_i;
            bst_col_r  <= addr_i[COL_W-1:0];
            bst_cnt_r  <= 9'h001;
        end else if (bst_stop) begin
            bst_act_r  <= 1'b0;
        end else if (rd_beat || wr_beat) begin
            bst_act_r  <= !beat_done;
            bst_cnt_r  <= bst_cnt_r + 9'h001;
        end
    end

    // Array writes honour the byte mask in the data cycle
    always_ff @(posedge clk_i) begin
        if (wr_beat) begin
            for (int l = 0; l < LANES; l++) begin
                if (!dqm_i[l]) mem_r[beat_addr][l*8 +: 8] <= dq_i[l*8 +: 8];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Per-bank state; later assignments take priority over timer progress
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            for (int b = 0; b < BANKS; b++) begin
                bank_st_r[b]  <= BK_IDLE;
                bank_tmr_r[b] <= '0;
                open_row_r[b] <= '0;
            end
        end else begin
            for (int b = 0; b < BANKS; b++) begin
                if (bank_st_r[b] == BK_ACTIVATING || bank_st_r[b] == BK_PRECHARGING) begin
                    if (bank_tmr_r[b] != '0) begin
                        bank_tmr_r[b] <= bank_tmr_r[b] - 4'h1;
                    end else begin
                        bank_st_r[b] <= (bank_st_r[b] == BK_ACTIVATING) ? BK_ACTIVE
                                                                        : BK_IDLE;
                    end
                end
                if (exec_act && ba_i == 2'(b)) begin
                    bank_st_r[b]  <= BK_ACTIVATING;
                    // Load edge and exit edge both count towards the delay
                    bank_tmr_r[b] <= 4'(T_RCD_CYC - 2);
                    open_row_r[b] <= addr_i;
                end
                // A new access elsewhere releases the interrupted bank
                if (exec_rdwr && bst_act_r && bst_bank_r == 2'(b) && ba_i != 2'(b)) begin
                    bank_st_r[b]  <= bst_ap_r ? BK_PRECHARGING : BK_ACTIVE;
                    bank_tmr_r[b] <= 4'(T_RP_CYC - 2);
                end
                if (exec_rdwr && ba_i == 2'(b)) begin
                    bank_st_r[b] <= is_wr ? BK_WRITING : BK_READING;
                end
                if (exec_term && bst_act_r && bst_bank_r == 2'(b)) begin
                    bank_st_r[b] <= BK_ACTIVE;
                end
                // Burst end closes the row only when auto precharge was asked
                if (burst_end && beat_bank == 2'(b)) begin
                    if (exec_rdwr ? addr_i[AP_BIT] : bst_ap_r) begin
                        bank_st_r[b]  <= BK_PRECHARGING;
                        bank_tmr_r[b] <= (exec_rdwr ? is_wr : bst_wr_r)
                                         ? 4'(T_WRAP_CYC + T_RP_CYC - 2)
                                         : 4'(T_RP_CYC - 2);
                    end else begin
                        bank_st_r[b] <= BK_ACTIVE;
                    end
                end
                if (exec_pre && (addr_i[AP_BIT] || ba_i == 2'(b))
                    && bank_st_r[b] != BK_IDLE) begin
                    bank_st_r[b]  <= BK_PRECHARGING;
                    bank_tmr_r[b] <= 4'(T_RP_CYC - 2);
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Refresh counter and self refresh; exit needs a short settle window
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            refresh_row_o  <= '0;
            self_refresh_o <= 1'b0;
            xsr_cnt_r      <= '0;
        end else begin
            if (exec_aref) refresh_row_o <= refresh_row_o + 12'h001;
            if (exec_sref) begin
                self_refresh_o <= 1'b1;
            end else if (self_refresh_o && cke_i) begin
                self_refresh_o <= 1'b0;
                xsr_cnt_r      <= 2'(T_XSR_CLK);
            end else if (xsr_cnt_r != '0) begin
                xsr_cnt_r <= xsr_cnt_r - 2'h1;
            end
        end
    end

    // Flag commands issued outside their legal state
    always_ff @(posedge clk_i) begin
        if (reset_i) illegal_cmd_o <= 1'b0;
        else         illegal_cmd_o <= accept && !legal;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read path: array word enters the FIFO, leaves at the read latency
    sdc_fifo #(
        .WIDTH (DQ_W),
        .DEPTH (RD_FIFO_DEPTH)
    ) u_rd_fifo (
        .clk_i       (clk_i),
        .reset_i     (reset_i),
        .in_valid_i  (rd_beat),
        .in_ready_o  (fifo_in_ready),
        .in_data_i   (mem_r[beat_addr]),
        .out_valid_o (fifo_out_valid),
        .out_ready_i (pop_due),
        .out_data_o  (fifo_out_data)
    );

    assign pop_due = cl3 ? due_r[1] : due_r[0];

    // Latency marks and mask pipeline; output stage is registered
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            due_r     <= '0;
            dqm_p1_r  <= '1;
            dq_o      <= '0;
            dq_oe_o   <= '0;
            out_vld_r <= 1'b0;
        end else begin
            due_r     <= {due_r[1:0], rd_beat};
            dqm_p1_r  <= dqm_i;
            out_vld_r <= pop_due && fifo_out_valid;
            dq_o      <= fifo_out_data;
            dq_oe_o   <= (pop_due && fifo_out_valid) ? ~dqm_p1_r : '0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks on the logic above
    AST_INHIBIT_NOEFFECT: assert property (@(posedge clk_i) disable iff (reset_i)
        strobe_i.cs_n |=> !illegal_cmd_o && $stable(mode_r))
        else $error("deselected cycle changed state");
    AST_MRD_GAP: assert property (@(posedge clk_i) disable iff (reset_i)
        exec_mode ##1 (accept && cmd == CMD_ACT) |=> illegal_cmd_o)
        else $error("activate accepted inside mode load delay");
    AST_ACT_OPENS: assert property (@(posedge clk_i) disable iff (reset_i)
        exec_act |=> bank_st_r[$past(ba_i)] == BK_ACTIVATING
                     && open_row_r[$past(ba_i)] == $past(addr_i))
        else $error("activate did not open the row");
    AST_RD_LATENCY: assert property (@(posedge clk_i) disable iff (reset_i)
        (exec_rdwr && !is_wr && !cl3) |-> ##2 out_vld_r)
        else $error("read data not out at latency two");
    AST_RD_MASK: assert property (@(posedge clk_i) disable iff (reset_i)
        dq_oe_o[0] |-> !$past(dqm_i[0], 2))
        else $error("masked read lane driven");
    AST_TERM_STOPS: assert property (@(posedge clk_i) disable iff (reset_i)
        (exec_term && bst_act_r) |=> !bst_act_r ##1 !bst_act_r)
        else $error("burst ran on after terminate");
    AST_PRE_ALL: assert property (@(posedge clk_i) disable iff (reset_i)
        (exec_pre && addr_i[AP_BIT] && !exec_act) |=> bank_st_r[0] != BK_ACTIVE
            && bank_st_r[1] != BK_ACTIVE && bank_st_r[2] != BK_ACTIVE
            && bank_st_r[3] != BK_ACTIVE)
        else $error("precharge all left a bank open");
    AST_SELF_REF: assert property (@(posedge clk_i) disable iff (reset_i)
        exec_sref |=> self_refresh_o)
        else $error("self refresh not entered");
    AST_AUTO_REF: assert property (@(posedge clk_i) disable iff (reset_i)
        exec_aref |=> refresh_row_o == $past(refresh_row_o) + 12'h001)
        else $error("refresh counter did not advance");

endmodule // sdc_core

// File: verilog/sdc_pkg.sv
// Package for the SDRAM command interface: pin bundles, commands, bank
// states, geometry (x16 organisation), mode register and timing counts.
// Assumes a single 200 MHz clock; the picosecond timings derive their cycle counts from it.
package sdc_pkg;

    // Geometry (x16 organisation)
    localparam int BANKS     = 4;
    localparam int ROW_W     = 12;
    localparam int COL_W     = 8;
    localparam int DQ_W      = 16;
    localparam int LANES     = 2;
    localparam int ROWS_4X   = 4096;
    localparam int COLS_X4   = 1024;
    localparam int COLS_X8   = 512;
    localparam int COLS_X16  = 256;
    localparam int AP_BIT    = 10;
    localparam int MEM_WORDS = BANKS * ROWS_4X * COLS_X16;

    // Mode register: {bank select, address}, burst length and latency fields
    localparam int            MODE_W      = 14;
    localparam logic [13:0]   MODE_RST    = 14'h0022;
    localparam int            MODE_BL_LSB = 0;
    localparam int            MODE_CL_LSB = 4;
    localparam logic [2:0]    CL_THREE    = 3'h3;
    localparam logic [2:0]    BL_FULLPAGE = 3'h7;

    // Timing in its own unit, then cycles at 200 MHz
    localparam int CLK_PS     = 5000;
    localparam int T_RCD_PS   = 20000;
    localparam int T_RP_PS    = 20000;
    localparam int T_WRAP_PS  = 7500;
    localparam int T_MRD_CLK  = 2;
    localparam int T_XSR_CLK  = 2;
    localparam int T_RCD_CYC  = (T_RCD_PS + CLK_PS - 1) / CLK_PS;
    localparam int T_RP_CYC   = (T_RP_PS + CLK_PS - 1) / CLK_PS;
    localparam int T_WRAP_CYC = 1 + (T_WRAP_PS + CLK_PS - 1) / CLK_PS;
    localparam int RD_FIFO_DEPTH = 4;

    // Strobe pins travel together
    typedef struct packed {
        logic cs_n;
        logic ras_n;
        logic cas_n;
        logic we_n;
    } sdc_strobe_t;

    typedef enum logic [3:0] {
        CMD_INHIBIT, CMD_NOP, CMD_ACT, CMD_READ, CMD_WRITE,
        CMD_TERM, CMD_PRE, CMD_REFRESH, CMD_MODE_LOAD
    } sdc_cmd_t;

    typedef enum logic [2:0] {
        BK_IDLE, BK_ACTIVATING, BK_ACTIVE, BK_READING, BK_WRITING, BK_PRECHARGING
    } sdc_bank_st_t;

    // Strobe decode
    function automatic sdc_cmd_t sdc_decode(input sdc_strobe_t s);
        sdc_cmd_t c;
        c = CMD_INHIBIT;
        if (!s.cs_n) begin
            unique case ({s.ras_n, s.cas_n, s.we_n})
                3'b111: c = CMD_NOP;
                3'b011: c = CMD_ACT;
                3'b101: c = CMD_READ;
                3'b100: c = CMD_WRITE;
                3'b110: c = CMD_TERM;
                3'b010: c = CMD_PRE;
                3'b001: c = CMD_REFRESH;
                3'b000: c = CMD_MODE_LOAD;
            endcase
        end
        return c;
    endfunction

endpackage
